/* timer_defs.svh */
// Constants for the 10-bit timer with PWM: register offsets, reset values,
// field positions, clock-divider masks and period figures.
// Assumes inclusion by the package and by the timer module alike.
//
// Summary of operation
// - Mode 11 behaves like compare mode but never drives the output pin.
// - Mode 10 makes a fixed-frequency, variable-duty waveform on the pin.
// - PWM mode ignores clear_on_a_select; the period register alone clears.
// - period_duty_swap 0: P is period, A duty; 1: A period, P duty.
// - Period code n gives n*128 clocks; code 000 gives 1024, full overflow.
// - PWM mode sets match_a_flag and match_p_flag on each own match.
// - PWM output_action passes the waveform or forces a fixed level.
// - output_invert inverts the pin level; no effect in timer mode.
// - Duty equal to or above period holds the output active all period.
// - Counting and matching go on while output_action forces the pin.
// - In PWM each period-match clear starts a new PWM period.
// - Core is a 10-bit up-counter on internal or external pin clock.
// - Comparator P checks bits 9..7 against the code and bits 6..0 for zero; comparator A all ten bits.
// - Software clears counter only by timer_on rise; hardware clears on matches.
// - timer_on 1 runs; 0 stops; rise zeroes count, fall keeps it.
// - Compare mode: timer_on rise returns pin to output_level_select level.
// - counter_pause holds the count; clearing it resumes from that value.
// - count_clock_select picks sys/4, sys, H/16, H/64, sub, external edges.
// - Count reads through low byte and high two bits; upper bits read zero.
// - Match A value sits in a read/write byte pair resetting to zero.
// - PWM output_action 00 inactive, 01 active, 10 waveform.
// - PWM output_level_select 1 means active high, 0 active low.
// - Non-PWM: select 0 clears on P match or overflow; 1 on A only.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
`define OFF_CTRL0 8'h00
`define OFF_CTRL1 8'h04
`define OFF_CNT_LO 8'h08
`define OFF_CNT_HI 8'h0C
`define OFF_A_LO 8'h10
`define OFF_A_HI 8'h14
`define OFF_FLAGS 8'h18
`define CTRL0_RESET 8'h00
`define CTRL1_RESET 8'h00
`define MATCH_A_RESET 10'h000
`define FLAG_A_BIT 0
`define FLAG_P_BIT 1
`define CTRL0_ON_BIT 3
`define COUNT_MAX 10'h3FF
`define FULL_PERIOD 11'h400
`define DIV4_MASK 6'h03
`define DIV16_MASK 6'h0F
`define DIV64_MASK 6'h3F
`define ACT_00 2'b00
`define ACT_01 2'b01
`define ACT_10 2'b10
`define ACT_11 2'b11
`endif

/* timer_pkg.sv */
// Types shared by the 10-bit timer: control register layouts and enumerations.
// Assumes the constants header is available on the include path.
`include "timer_defs.svh"
package timer_pkg;
    typedef enum logic [1:0] {MODE_COMPARE, MODE_RESERVED, MODE_PWM, MODE_TIMER} mode_t;
    typedef enum logic [2:0] {CLK_SYS_DIV4, CLK_SYS, CLK_H_DIV16, CLK_H_DIV64, CLK_SUB, CLK_UNDEF,
                              CLK_EXT_RISE, CLK_EXT_FALL} clk_sel_t;
    // First control register, bit 7 down to bit 0.
    typedef struct packed {
        logic counter_pause;
        clk_sel_t count_clock_select;
        logic timer_on;
        logic [2:0] period_code;
    } ctrl0_t;
    // Second control register, bit 7 down to bit 0.
    typedef struct packed {
        mode_t mode_select;
        logic [1:0] output_action;
        logic output_level_select;
        logic output_invert;
        logic period_duty_swap;
        logic clear_on_a_select;
    } ctrl1_t;
endpackage

/* ten_bit_timer_pwm.sv */
// The 10-bit timer with compare output, PWM and timer/counter modes, behind
// an APB slave. Assumes pclk is the system clock and also the high clock,
// and that sub_clock and external_count_pin are levels from outside.
`include "timer_defs.svh"
module ten_bit_timer_pwm
    import timer_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Count sources.
    input wire logic sub_clock,
    input wire logic external_count_pin,
    // Timer output pin.
    output logic timer_output_pin_o,
    output logic timer_output_pin_oe
);

    ctrl0_t ctrl0_reg;
    ctrl1_t ctrl1_reg;
    logic [9:0] match_a_reg;
    logic [9:0] cnt_reg;
    logic flag_a_reg;
    logic flag_p_reg;
    logic level_reg;
    logic pin_reg;
    logic oe_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [5:0] pre_reg;
    logic ext_meta_reg;
    logic ext_sync_reg;
    logic ext_prev_reg;
    logic sub_prev_reg;

    logic wr;
    logic rd_load;
    ctrl0_t wr0;
    logic on_rise;
    logic tick;
    logic count_en;
    logic [9:0] inc;
    logic a_hit;
    logic p_hit;
    logic clear_hit;
    logic a_set;
    logic p_set;
    logic is_pwm;
    logic [10:0] p_len;
    logic [10:0] a_len;
    logic [10:0] period;
    logic [10:0] duty;
    logic pwm_active;
    logic pin_next;
    logic [7:0] rd_byte;
    logic rd_hit;

    // Ports come straight from flip-flops.
    // No output has a path from an input.
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign timer_output_pin_o = pin_reg;
    assign timer_output_pin_oe = oe_reg;

    // A write lands at the edge where the master sees pready high.
    // A read is loaded early, in the wait state.
    assign wr = psel & penable & pready_reg & pwrite;
    assign rd_load = psel & penable & ~pready_reg;
    assign wr0 = ctrl0_t'(pwdata[7:0]);
    // Only a write turning timer_on from 0 to 1 restarts the counter.
    // It also reloads the compare level from output_level_select.
    assign on_rise = wr & (paddr == `OFF_CTRL0) & pwdata[`CTRL0_ON_BIT] & ~ctrl0_reg.timer_on;
    assign is_pwm = (ctrl1_reg.mode_select == MODE_PWM);

    // APB handshake: one wait state, so every access phase lasts two cycles.
    // The wait gives the read mux a full cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= rd_load;
        end
    end

    // Read data and error are loaded together with pready.
    // Data stays after the access; pslverr drops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (rd_load) begin
            prdata_reg <= {24'h00_0000, rd_byte};
            pslverr_reg <= ~rd_hit;
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // Read multiplexer; bits above each implemented field read as zero.
    // The count pair is not latched; a carry can tear it.
    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            `OFF_CTRL0: rd_byte = ctrl0_reg;
            `OFF_CTRL1: rd_byte = ctrl1_reg;
            `OFF_CNT_LO: rd_byte = cnt_reg[7:0];
            `OFF_CNT_HI: rd_byte = {6'h00, cnt_reg[9:8]};
            `OFF_A_LO: rd_byte = match_a_reg[7:0];
            `OFF_A_HI: rd_byte = {6'h00, match_a_reg[9:8]};
            `OFF_FLAGS: rd_byte = {6'h00, flag_p_reg, flag_a_reg};
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Control registers. Mode and action should be changed only while stopped.
    // on_rise sees the old timer_on; a second 1 is no restart.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg <= ctrl0_t'(`CTRL0_RESET);
            ctrl1_reg <= ctrl1_t'(`CTRL1_RESET);
        end else if (wr) begin
            if (paddr == `OFF_CTRL0) begin
                ctrl0_reg <= wr0;
            end
            if (paddr == `OFF_CTRL1) begin
                ctrl1_reg <= ctrl1_t'(pwdata[7:0]);
            end
        end
    end

    // Match A value as a byte pair; the high write keeps only two bits.
    // Either half may be written first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_a_reg <= `MATCH_A_RESET;
        end else if (wr && paddr == `OFF_A_LO) begin
            match_a_reg[7:0] <= pwdata[7:0];
        end else if (wr && paddr == `OFF_A_HI) begin
            match_a_reg[9:8] <= pwdata[1:0];
        end
    end

    // Free-running prescaler shared by the divided internal sources.
    // Sharing it saves counters, but the first tick after a
    // start may come up to one divider period early.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 6'h00;
        end else begin
            pre_reg <= pre_reg + 6'h01;
        end
    end

    // Two-flop synchroniser, then a third stage for edge detection.
    // The detector compares the second and third stages; the first never feeds it.
    // A pin level must stand one full clock, or an edge can be lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
            sub_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= external_count_pin;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
            sub_prev_reg <= sub_clock;
        end
    end

    // Source select; the reserved code gives no ticks at all.
    // One previous-value flop catches the slow sub clock edge.
    always_comb begin
        case (ctrl0_reg.count_clock_select)
            CLK_SYS_DIV4: tick = ((pre_reg & `DIV4_MASK) == `DIV4_MASK);
            CLK_SYS: tick = 1'b1;
            CLK_H_DIV16: tick = ((pre_reg & `DIV16_MASK) == `DIV16_MASK);
            CLK_H_DIV64: tick = (pre_reg == `DIV64_MASK);
            CLK_SUB: tick = sub_clock & ~sub_prev_reg;
            CLK_EXT_RISE: tick = ext_sync_reg & ~ext_prev_reg;
            CLK_EXT_FALL: tick = ~ext_sync_reg & ext_prev_reg;
            default: tick = 1'b0;
        endcase
    end

    // A match is judged on the value the counter is about to take.
    assign count_en = ctrl0_reg.timer_on & ~ctrl0_reg.counter_pause & tick;
    assign inc = cnt_reg + 10'h001;
    // P matches only on entering a 128-multiple; code 000 matches at wrap.
    // A value of zero never matches; it means overflow.
    assign p_hit = (inc[9:7] == ctrl0_reg.period_code) && (inc[6:0] == 7'h00);
    assign a_hit = (inc == match_a_reg) && (match_a_reg != 10'h000);

    // Clear source: PWM follows the period register only.
    // Judged on the next value, a clear takes the place of
    // the step that would reach the match.
    always_comb begin
        if (is_pwm) begin
            clear_hit = ctrl1_reg.period_duty_swap ? a_hit : p_hit;
        end else begin
            clear_hit = ctrl1_reg.clear_on_a_select ? a_hit : p_hit;
        end
    end

    // Flags follow real steps only, never a stopped count.
    assign a_set = count_en & a_hit;
    // With clear-on-A outside PWM, the P flag stays silent.
    assign p_set = count_en & p_hit & (is_pwm | ~ctrl1_reg.clear_on_a_select);

    // The counter: only a timer_on rise lets software move it.
    // A restart wins over a step, so a start begins at zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 10'h000;
        end else if (on_rise) begin
            cnt_reg <= 10'h000;
        end else if (count_en) begin
            cnt_reg <= clear_hit ? 10'h000 : inc;
        end
    end

    // Match flags: write one to clear, and a new match beats the clear.
    // A clear in the match cycle leaves the flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_a_reg <= 1'b0;
            flag_p_reg <= 1'b0;
        end else begin
            flag_a_reg <= a_set | (flag_a_reg & ~(wr && paddr == `OFF_FLAGS && pwdata[`FLAG_A_BIT]));
            flag_p_reg <= p_set | (flag_p_reg & ~(wr && paddr == `OFF_FLAGS && pwdata[`FLAG_P_BIT]));
        end
    end

    // Lengths in timer clocks; code 000 and A value 0 mean full overflow.
    // Eleven bits hold 1024 without wrapping to zero.
    assign p_len = (ctrl0_reg.period_code == 3'b000) ? `FULL_PERIOD : {1'b0, ctrl0_reg.period_code, 7'h00};
    assign a_len = (match_a_reg == 10'h000) ? `FULL_PERIOD : {1'b0, match_a_reg};
    assign period = ctrl1_reg.period_duty_swap ? a_len : p_len;
    assign duty = ctrl1_reg.period_duty_swap ? p_len : {1'b0, match_a_reg};
    // A new period starts with every clear, since the count falls to zero.
    assign pwm_active = (duty >= period) | ({1'b0, cnt_reg} < duty);

    // Compare-mode pin level before polarity; only A matches and a timer_on rise move it.
    // An action equal to the level shows no change.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= 1'b0;
        end else if (on_rise) begin
            level_reg <= ctrl1_reg.output_level_select;
        end else if (a_set && ctrl1_reg.mode_select != MODE_PWM) begin
            case (ctrl1_reg.output_action)
                `ACT_01: level_reg <= 1'b0;
                `ACT_10: level_reg <= 1'b1;
                `ACT_11: level_reg <= ~level_reg;
                default: level_reg <= level_reg;
            endcase
        end
    end

    // Pin level. Forcing only overrides the drive; counting carries on.
    // Action 11 is undefined in PWM and drives inactive.
    always_comb begin
        pin_next = level_reg;
        if (is_pwm) begin
            case (ctrl1_reg.output_action)
                `ACT_00: pin_next = ~ctrl1_reg.output_level_select;
                `ACT_01: pin_next = ctrl1_reg.output_level_select;
                `ACT_10: pin_next = pwm_active ~^ ctrl1_reg.output_level_select;
                default: pin_next = ~ctrl1_reg.output_level_select;
            endcase
        end
        if (ctrl1_reg.mode_select != MODE_TIMER) begin
            pin_next = pin_next ^ ctrl1_reg.output_invert;
        end
    end

    // Pin and enable; timer mode leaves the pin to other functions.
    // Both come from flops and move on the same edge.
    // Mode 01 is reserved: it counts as compare with the pin off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
            oe_reg <= (ctrl1_reg.mode_select == MODE_COMPARE) | is_pwm;
        end
    end

    // Checks on the behaviour above.
    // They are idle in reset, so no history from it is judged.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    counter_restart_a: assert property (on_rise |=> cnt_reg == 10'h000)
        else $error("counter not zeroed by timer_on rise");

    counter_pause_a: assert property ((ctrl0_reg.counter_pause && !on_rise) [*2] |-> $stable(cnt_reg))
        else $error("counter moved while paused");

    counter_off_a: assert property ((!ctrl0_reg.timer_on && !on_rise) |=> $stable(cnt_reg))
        else $error("counter moved while off");

    counter_wrap_a: assert property ((count_en && !on_rise && cnt_reg == `COUNT_MAX) |=> cnt_reg == 10'h000)
        else $error("counter did not wrap to zero");

    period_clear_a: assert property ((count_en && !on_rise && is_pwm && !ctrl1_reg.period_duty_swap && p_hit)
        |=> cnt_reg == 10'h000 && flag_p_reg)
        else $error("period match did not clear and flag");

    p_flag_quiet_a: assert property ((!is_pwm && ctrl1_reg.clear_on_a_select && !flag_p_reg
        && !(wr && paddr == `OFF_FLAGS)) |=> !flag_p_reg)
        else $error("P flag raised with clear on A");

    flag_set_wins_a: assert property (a_set |=> flag_a_reg)
        else $error("A match flag lost");

    timer_pin_free_a: assert property ((ctrl1_reg.mode_select == MODE_TIMER) |=> !timer_output_pin_oe)
        else $error("pin driven in timer mode");

    pwm_force_a: assert property ((is_pwm && ctrl1_reg.output_action == `ACT_00) |=>
        timer_output_pin_o == ($past(~ctrl1_reg.output_level_select) ^ $past(ctrl1_reg.output_invert)))
        else $error("forced inactive level wrong");

    full_duty_a: assert property ((is_pwm && ctrl1_reg.output_action == `ACT_10 && duty >= period) |=>
        timer_output_pin_o == ($past(ctrl1_reg.output_level_select) ^ $past(ctrl1_reg.output_invert)))
        else $error("full duty not held active");

    compare_init_a: assert property ((on_rise && ctrl1_reg.mode_select == MODE_COMPARE) |=>
        level_reg == $past(ctrl1_reg.output_level_select))
        else $error("pin level not restored on start");

    apb_ready_a: assert property ((psel && penable && !pready) |=> pready ##1 !pready)
        else $error("pready not a single cycle after one wait");

    pwm_oe_a: assert property (is_pwm |=> timer_output_pin_oe)
        else $error("pin not driven in PWM");

    pwm_no_a_clear_a: assert property ((count_en && !on_rise && is_pwm && a_hit && !p_hit
        && !ctrl1_reg.period_duty_swap) |=> cnt_reg == $past(inc))
        else $error("A match cleared the PWM counter");

    pwm_swap_clear_a: assert property ((count_en && !on_rise && is_pwm && a_hit
        && ctrl1_reg.period_duty_swap) |=> cnt_reg == 10'h000)
        else $error("A period match did not clear");

    pwm_flag_p_a: assert property ((count_en && is_pwm && p_hit) |=> flag_p_reg)
        else $error("P flag not set in PWM");

    count_step_a: assert property ((count_en && !on_rise && !clear_hit) |=> cnt_reg == $past(inc))
        else $error("counter did not step by one");

    count_high_read_a: assert property ((rd_load && paddr == `OFF_CNT_HI)
        |=> prdata[31:2] == 30'h0000_0000)
        else $error("unused count bits not zero");

    level_hold_a: assert property ((!on_rise && !a_set) |=> $stable(level_reg))
        else $error("compare level moved without a match");

    // Cover points for the main scenarios.
    pwm_period_c: cover property (is_pwm && count_en && clear_hit);
    compare_toggle_c: cover property (a_set && ctrl1_reg.mode_select == MODE_COMPARE
        && ctrl1_reg.output_action == `ACT_11);
    ext_edge_c: cover property (count_en && ctrl0_reg.count_clock_select == CLK_EXT_FALL);
    flag_clear_race_c: cover property (a_set && wr && paddr == `OFF_FLAGS && pwdata[`FLAG_A_BIT]);
    pwm_swap_c: cover property (is_pwm && ctrl1_reg.period_duty_swap && count_en && a_hit);

endmodule

/* ext_count_source.sv */
// Behavioural source for the external count pin of the timer.
// Assumes the caller enters send_edges just after a rising edge of pclk.
module ext_count_source (
    // Clock.
    input wire logic pclk,
    // Pin toward the timer.
    output logic external_count_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // The pin rests low between bursts, as a pulled-down line would.
    initial begin
        external_count_pin = 1'b0;
    end
    // Each pulse holds both levels for gap cycles, long enough for a two-flop synchroniser.
    task automatic send_edges(input int n, input int gap);
        repeat (n) begin
            external_count_pin <= 1'b1;
            repeat (gap) @(posedge pclk);
            external_count_pin <= 1'b0;
            repeat (gap) @(posedge pclk);
        end
    endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the 10-bit timer: APB master, scenario tasks, verdict.
// Assumes the timer package, the timer module and the count source are compiled first.
`include "timer_defs.svh"
module tb_top
    import timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sub_clock, pin_o, pin_oe, e;
    logic external_count_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d;
    int n_errors, n_tests, cnt;
    ten_bit_timer_pwm DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sub_clock(sub_clock), .external_count_pin(external_count_pin),
        .timer_output_pin_o(pin_o), .timer_output_pin_oe(pin_oe));
    ext_count_source src (.pclk(pclk), .external_count_pin(external_count_pin));
    // Clock at 25 MHz.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Slow sub clock, ten pclk cycles a period, so its ticks are easy to count.
    initial begin
        sub_clock = 1'b0;
        forever begin
            repeat (5) @(posedge pclk);
            sub_clock <= ~sub_clock;
        end
    end
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; read data and error land in d and e at the pready edge.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // The pair is read one byte at a time, so callers stop the counter first.
    task automatic read_count();
        logic [7:0] lo;
        apb(1'b0, `OFF_CNT_LO, 32'h0);
        lo = d[7:0];
        apb(1'b0, `OFF_CNT_HI, 32'h0);
        chk("count high unused", d & 32'hFFFF_FFFC, 32'h0);
        cnt = {d[1:0], lo};
    endtask
    // Stop, set mode, then start so each run begins with a rising timer_on.
    task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
        apb(1'b1, `OFF_CTRL0, 32'h0);
        apb(1'b1, `OFF_CTRL1, {24'h0, c1});
        apb(1'b1, `OFF_CTRL0, {24'h0, c0});
    endtask
    task automatic s_reset();
        logic [7:0] a [6] = '{`OFF_CTRL0, `OFF_CTRL1, `OFF_CNT_LO, `OFF_CNT_HI, `OFF_A_LO, `OFF_A_HI};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, a[i], 32'h0);
            chk("reset value", d, 32'h0);
        end
        chk("oe after reset", 32'(pin_oe), 32'h1);
        apb(1'b1, `OFF_CNT_LO, 32'h0000_00FF);
        apb(1'b0, `OFF_CNT_LO, 32'h0);
        chk("count write ignored", d, 32'h0);
        apb(1'b1, 8'h1C, 32'h0000_00FF);
        chk("unmapped write error", 32'(e), 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped read", {d[30:0], e}, 32'h1);
        apb(1'b1, `OFF_A_LO, 32'h0000_00A5);
        apb(1'b1, `OFF_A_HI, 32'h0000_00FF);
        apb(1'b0, `OFF_A_LO, 32'h0);
        chk("match a low", d, 32'h0000_00A5);
        apb(1'b0, `OFF_A_HI, 32'h0);
        chk("match a high", d, 32'h0000_0003);
    endtask
    task automatic s_clocks();
        int ex [6] = '{128, 515, 32, 8, 51, 0};
        int tol [6] = '{2, 4, 1, 1, 2, 0};
        int v;
        for (int i = 0; i < 6; i++) begin
            cfg(8'h00, {1'b0, 3'(i), 4'h8});
            repeat (512) @(posedge pclk);
            apb(1'b1, `OFF_CTRL0, {24'h0, 1'b1, 3'(i), 4'h8});
            read_count();
            v = (cnt > ex[i]) ? cnt - ex[i] : ex[i] - cnt;
            chk("ticks per source", 32'(v <= tol[i]), 32'h1);
        end
        cfg(8'h00, 8'h18);
        repeat (1030) @(posedge pclk);
        apb(1'b1, `OFF_CTRL0, 32'h0000_0098);
        read_count();
        chk("wrap past top", 32'(cnt < 40), 32'h1);
        apb(1'b1, `OFF_CTRL0, 32'h0000_0018);
        repeat (40) @(posedge pclk);
        apb(1'b1, `OFF_CTRL0, 32'h0000_0098);
        read_count();
        v = cnt;
        repeat (40) @(posedge pclk);
        read_count();
        chk("held in pause", 32'(cnt), 32'(v));
        apb(1'b1, `OFF_CTRL0, 32'h0000_0018);
        apb(1'b1, `OFF_CTRL0, 32'h0000_0010);
        read_count();
        chk("resume from held", 32'(cnt > v && cnt < v + 10), 32'h1);
        v = cnt;
        repeat (40) @(posedge pclk);
        read_count();
        chk("kept when off", 32'(cnt), 32'(v));
        apb(1'b1, `OFF_CTRL0, 32'h0000_0018);
        apb(1'b1, `OFF_CTRL0, 32'h0000_0098);
        read_count();
        chk("zeroed on start", 32'(cnt < 10), 32'h1);
    endtask
    // Rising then falling external edges; each pulse must count once.
    task automatic s_ext();
        for (int i = 0; i < 2; i++) begin
            cfg(8'h00, i ? 8'h78 : 8'h68);
            src.send_edges(5 - 2 * i, 4);
            repeat (6) @(posedge pclk);
            apb(1'b1, `OFF_CTRL0, i ? 32'h0000_00F8 : 32'h0000_00E8);
            read_count();
            chk("external edges", 32'(cnt), 32'(5 - 2 * i));
        end
    endtask
    task automatic s_compare();
        apb(1'b1, `OFF_A_LO, 32'h0000_0064);
        apb(1'b1, `OFF_A_HI, 32'h0);
        for (int i = 0; i < 2; i++) begin
            cfg(i ? 8'hC0 : 8'hC1, i ? 8'h19 : 8'h18);
            apb(1'b1, `OFF_FLAGS, 32'h0000_0003);
            repeat (300) @(posedge pclk);
            apb(1'b0, `OFF_FLAGS, 32'h0);
            chk("match flags", d, i ? 32'h0000_0003 : 32'h0000_0001);
            chk("pin released", 32'(pin_oe), 32'h0);
            apb(1'b1, `OFF_CTRL0, i ? 32'h0000_0099 : 32'h0000_0098);
            read_count();
            chk("cleared on match", 32'(cnt < (i ? 128 : 101)), 32'h1);
        end
        for (int i = 0; i < 2; i++) begin
            cfg(i ? 8'h00 : 8'h08, 8'h18);
            repeat (2) @(posedge pclk);
            chk("initial level", {pin_oe, pin_o}, {31'h1, ~1'(i)});
        end
        // Output low, output high and toggle on the A match at 100.
        for (int i = 1; i < 4; i++) begin
            cfg({2'b00, 2'(i), 1'(i != 2), 3'b000}, 8'h18);
            repeat (110) @(posedge pclk);
            chk("action on match", 32'(pin_o), 32'(i == 2));
        end
        cfg(8'h38, 8'h18);
        repeat (2) @(posedge pclk);
        chk("level after restart", 32'(pin_o), 32'h1);
    endtask
    task automatic s_pwm();
        logic [7:0] c1 [7] = '{8'hA9, 8'hAC, 8'hA0, 8'h88, 8'h98, 8'hA8, 8'hAA};
        logic [9:0] av [7] = '{10'h020, 10'h020, 10'h020, 10'h020, 10'h020, 10'h0C8, 10'h180};
        int len [7] = '{128, 128, 128, 128, 128, 128, 384};
        int act [7] = '{32, 96, 96, 0, 128, 128, 128};
        logic [31:0] fl [7] = '{3, 3, 3, 3, 3, 2, 3};
        int h;
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `OFF_A_LO, {24'h0, av[i][7:0]});
            apb(1'b1, `OFF_A_HI, {30'h0, av[i][9:8]});
            cfg(c1[i], 8'h19);
            repeat (8) @(posedge pclk);
            apb(1'b1, `OFF_FLAGS, 32'h0000_0003);
            h = 0;
            repeat (len[i]) begin
                @(posedge pclk);
                h += (pin_o === 1'b1);
            end
            chk("active cycles", 32'(h), 32'(act[i]));
            apb(1'b0, `OFF_FLAGS, 32'h0);
            chk("pwm flags", d, fl[i]);
        end
    endtask
    // Whole-run limit: a hang counts as a mismatch.
    initial begin
        repeat (100000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
    // Reset for three cycles, then every scenario in turn.
    initial begin
        n_errors = 0;
        n_tests = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_reset();
        s_clocks();
        s_ext();
        s_compare();
        s_pwm();
        end_of_test();
    end
endmodule
